//--- rtl/ppc_regs.svh
`ifndef PPC_REGS_SVH
`define PPC_REGS_SVH
// Register byte offsets
`define PPC_OFF_CTRL   8'h00
`define PPC_OFF_MSTAT  8'h04
`define PPC_OFF_CS1BS  8'h08
`define PPC_OFF_CS2BS  8'h0c
`define PPC_OFF_CS1MD  8'h10
`define PPC_OFF_CS2MD  8'h14
`define PPC_OFF_SSTAT  8'h18
`define PPC_OFF_PAD    8'h1c
`define PPC_OFF_MADDR  8'h20
`define PPC_OFF_MWDATA 8'h24
`define PPC_OFF_MCMD   8'h28
`define PPC_OFF_MRDATA 8'h2c
`define PPC_OFF_BUF0   8'h30
`define PPC_OFF_BUF3   8'h3c
// Reset values and writable masks
`define PPC_RST_CS1BS  16'h0080
`define PPC_RST_CS2BS  16'h8080
`define PPC_MSK_BS     16'hff88
`define PPC_MSK_MD     16'hf8ff
`define PPC_MSK_CTRL   16'h0303
`define PPC_MSK_PAD    16'h8001
// Field positions
`define PPC_F_ACKMODE  15:14
`define PPC_F_AMW      13:11
`define PPC_F_DSETUP   7:6
`define PPC_F_DSTRB    5:2
`define PPC_F_DHOLD    1:0
`define PPC_F_MODE     9:8
`define PPC_F_IRQMODE  1:0
`define PPC_F_BASEHI   15:7
`define PPC_F_BASEBIT  3
`define PPC_F_INFULL   15
`define PPC_F_INOVF    14
`define PPC_F_IBX      11:8
`define PPC_F_OUTEMPTY 7
`define PPC_F_OUTUNF   6
`define PPC_F_OBX      3:0
`define PPC_F_BUSY     15
`define PPC_F_ERR      13
`define PPC_F_TMO      12
`define PPC_F_PTTL     0
`define PPC_F_MCMD_RD  0
// Field encodings
`define PPC_ACK_NONE   2'h0
`define PPC_ACK_TMO    2'h1
`define PPC_ACK_WAIT   2'h2
`define PPC_ACK_RSV    2'h3
`define PPC_MODE_LEG   2'h0
`define PPC_MODE_BUF   2'h1
`define PPC_MODE_ADR   2'h2
`define PPC_MODE_MST   2'h3
`define PPC_IRQ_END    2'h1
`define PPC_IRQ_BUF3   2'h3
`define PPC_LAST_BUF   2'h3
// Timing: one clock is a quarter of an instruction cycle
`define PPC_TCY_NS     400
`define PPC_CLK_NS     100
`define PPC_TPT        (`PPC_TCY_NS / `PPC_CLK_NS)
`define PPC_QTR        (`PPC_TPT / 4)
`define PPC_TMO_TCY    255
`define PPC_AMW_MIN    3
`endif

//--- rtl/ppc_pkg.sv
package ppc_pkg;
  typedef enum logic [2:0] {
    PPC_MS_IDLE   = 3'b000,
    PPC_MS_AMW    = 3'b001,
    PPC_MS_SETUP  = 3'b010,
    PPC_MS_STROBE = 3'b011,
    PPC_MS_HOLD   = 3'b100
  } ppc_ms_t;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [1:0] addr;
    logic [7:0] din;
    logic       ack;
  } ppc_pin_t;

  typedef struct packed {
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [15:0]       ctrl;
    logic [1:0][15:0]  base;
    logic [1:0][15:0]  md;
    logic [15:0]       pad;
    logic              in_ovf;
    logic              out_unf;
    logic [3:0]        ib_full;
    logic [3:0]        ob_empty;
    logic [3:0][7:0]   ibuf;
    logic [3:0][7:0]   out_buf;
    logic [1:0]        wptr;
    logic [1:0]        rptr;
    ppc_ms_t           ms;
    logic [11:0]       cnt;
    logic [11:0]       tmo_cnt;
    logic [15:0]       cur_md;
    logic              busy;
    logic              err;
    logic              tmo;
    logic              is_rd;
    logic [23:0]       maddr;
    logic [7:0]        mwdata;
    logic [7:0]        mrdata;
    logic              cs1;
    logic              cs2;
    logic              rd;
    logic              wr;
    logic [7:0]        pd_out;
    logic              pd_oe_n;
    logic              irq;
    ppc_pin_t          s1;
    ppc_pin_t          s2;
    ppc_pin_t          s3;
  } ppc_state_t;
endpackage

//--- rtl/ppc_top.sv
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "ppc_regs.svh"
// Summary of operation
// - Reset loads chip-select 1 base with 0080h, chip-select 2 base with 8080h.
// - Base 2 written all zero lets chip-select 1 span to FFFFFFh.
// - Ack mode 00 ignores ack, 10 waits ack, 01 ack with time-out, 11 reserved.
// - Time-out limit is 255 cycles at strobe wait 0000, else that field.
// - Alternate master wait lasts three cycles plus the field value.
// - Data setup before strobe lasts field value plus a quarter cycle.
// - Write strobe lasts strobe wait plus one half cycle when ack mode is 00.
// - Read strobe lasts strobe wait plus three quarters of a cycle when ack mode is 00.
// - Hold after strobe: field plus quarter for writes, whole field for reads.
// - Input-full flag is set only while every writable input buffer holds data.
// - External write to a full input buffer sets sticky overflow until cleared.
// - Per-buffer input flag set on unread data, cleared when software reads it.
// - Output-empty flag resets to one, set when all output buffers in use are empty.
// - External read of an empty output buffer sets sticky underflow flag.
// - Per-buffer output-empty flags reset to one, clear on software write.
// - Buffer flags clear per word pair: bytes 0/1 together, bytes 2/3 together.
// - Port mode: 11 master, 10 addressable slave, 01 buffered, 00 legacy.
// - Interrupt mode 11 fires on buffer 3 access or address 3 access.
// - Master transaction ended by ack time-out sets sticky time-out flag.
module ppc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Shared data bus
  input  wire logic [7:0]  pd_in,
  output logic      [7:0]  pd_out,
  output logic             pd_oe_n,
  // Slave strobes from the outside party
  input  wire logic        ext_cs,
  input  wire logic        ext_rd,
  input  wire logic        ext_wr,
  input  wire logic [1:0]  ext_addr,
  // Master side
  input  wire logic        acknowledge_input,
  output logic      [23:0] ms_addr,
  output logic             ms_cs1,
  output logic             ms_cs2,
  output logic             ms_rd,
  output logic             ms_wr,
  // Miscellaneous
  output logic             irq_pulse,
  output logic             input_buffer_type
);

  ppc_pkg::ppc_state_t st_r;
  ppc_pkg::ppc_state_t st_nxt;
  logic [15:0] sstat;
  logic [23:0] b1;
  logic [23:0] b2;
  logic        cs1_hit;
  logic        cs2_hit;
  logic        apb_acc;
  logic        is_buf;
  logic [1:0]  bidx;
  logic        slave_on;
  logic        x_wr_end;
  logic        x_rd_end;
  logic [1:0]  x_widx;
  logic [1:0]  x_ridx;
  logic        fin;
  logic        strb_end;
  logic [11:0] hold_t;
  logic [11:0] tmo_lim;
  logic [1:0]  ack_sel;
  logic [1:0]  mode;
  logic [11:0] sl_q;

  // Status word built from live flags
  always_comb begin
    sstat = '0;
    mode = st_r.ctrl[`PPC_F_MODE];
    sstat[`PPC_F_IBX] = st_r.ib_full;
    sstat[`PPC_F_OBX] = st_r.ob_empty;
    sstat[`PPC_F_INOVF] = st_r.in_ovf;
    sstat[`PPC_F_OUTUNF] = st_r.out_unf;
    // Legacy mode has only buffer 0 in use
    if (mode == `PPC_MODE_LEG) begin
      sstat[`PPC_F_INFULL] = st_r.ib_full[0];
      sstat[`PPC_F_OUTEMPTY] = st_r.ob_empty[0];
    end else begin
      sstat[`PPC_F_INFULL] = &st_r.ib_full;
      sstat[`PPC_F_OUTEMPTY] = &st_r.ob_empty;
    end
  end

  // Chip-select decode of the master address
  always_comb begin
    b1 = {st_r.base[0][`PPC_F_BASEHI], 3'h0, st_r.base[0][`PPC_F_BASEBIT], 11'h000};
    b2 = {st_r.base[1][`PPC_F_BASEHI], 3'h0, st_r.base[1][`PPC_F_BASEBIT], 11'h000};
    // All-zero base 2 disables chip-select 2, so chip-select 1 runs to the top
    cs2_hit = (st_r.base[1] != 16'h0000) && (st_r.maddr >= b2);
    cs1_hit = !cs2_hit && (st_r.maddr >= b1);
  end

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    fin = 1'b0;
    strb_end = 1'b0;
    ack_sel = st_r.cur_md[`PPC_F_ACKMODE];
    hold_t = '0;
    tmo_lim = '0;
    is_buf = (paddr >= `PPC_OFF_BUF0) && (paddr <= `PPC_OFF_BUF3) && (paddr[1:0] == 2'h0);
    bidx = 2'((paddr - `PPC_OFF_BUF0) >> 2);
    apb_acc = psel & penable & st_r.pready;
    slave_on = (mode != `PPC_MODE_MST);
    // Pins go through three flops, edges are taken between stage two and three
    st_nxt.s1.cs = ext_cs;
    st_nxt.s1.rd = ext_rd;
    st_nxt.s1.wr = ext_wr;
    st_nxt.s1.addr = ext_addr;
    st_nxt.s1.din = pd_in;
    st_nxt.s1.ack = acknowledge_input;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.irq = 1'b0;
    x_wr_end = slave_on & st_r.s3.cs & st_r.s3.wr & ~st_r.s2.wr;
    x_rd_end = slave_on & st_r.s3.cs & st_r.s3.rd & ~st_r.s2.rd;
    // Buffer index per port mode
    case (mode)
      `PPC_MODE_ADR: begin
        x_widx = st_r.s3.addr;
        x_ridx = st_r.s3.addr;
      end
      `PPC_MODE_BUF: begin
        x_widx = st_r.wptr;
        x_ridx = st_r.rptr;
      end
      default: begin
        x_widx = 2'h0;
        x_ridx = 2'h0;
      end
    endcase

    // APB: one wait cycle so read data leaves a flop
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = '0;
      case (paddr)
        `PPC_OFF_CTRL:   st_nxt.prdata = 32'(st_r.ctrl);
        `PPC_OFF_MSTAT:  st_nxt.prdata = 32'({st_r.busy, 1'b0, st_r.err, st_r.tmo, 12'h000});
        `PPC_OFF_CS1BS:  st_nxt.prdata = 32'(st_r.base[0]);
        `PPC_OFF_CS2BS:  st_nxt.prdata = 32'(st_r.base[1]);
        `PPC_OFF_CS1MD:  st_nxt.prdata = 32'(st_r.md[0]);
        `PPC_OFF_CS2MD:  st_nxt.prdata = 32'(st_r.md[1]);
        `PPC_OFF_SSTAT:  st_nxt.prdata = 32'(sstat);
        `PPC_OFF_PAD:    st_nxt.prdata = 32'(st_r.pad);
        `PPC_OFF_MADDR:  st_nxt.prdata = 32'(st_r.maddr);
        `PPC_OFF_MWDATA: st_nxt.prdata = 32'(st_r.mwdata);
        `PPC_OFF_MCMD:   st_nxt.prdata = 32'(st_r.is_rd);
        `PPC_OFF_MRDATA: st_nxt.prdata = 32'(st_r.mrdata);
        default: begin
          if (is_buf) begin
            st_nxt.prdata = 32'(st_r.ibuf[bidx]);
          end else begin
            st_nxt.pslverr = !pwrite;
            if (pwrite) begin
              st_nxt.pslverr = 1'b1;
            end
          end
        end
      endcase
    end else begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // Software clears come first so that hardware sets below win, except the output-empty pair
    if (apb_acc && !pwrite && is_buf) begin
      st_nxt.ib_full[{bidx[1], 1'b0} +: 2] = 2'b00;
    end
    if (apb_acc && pwrite) begin
      case (paddr)
        `PPC_OFF_CTRL:   st_nxt.ctrl = pwdata[15:0] & `PPC_MSK_CTRL;
        `PPC_OFF_CS1BS:  st_nxt.base[0] = pwdata[15:0] & `PPC_MSK_BS;
        `PPC_OFF_CS2BS:  st_nxt.base[1] = pwdata[15:0] & `PPC_MSK_BS;
        `PPC_OFF_CS1MD:  st_nxt.md[0] = pwdata[15:0] & `PPC_MSK_MD;
        `PPC_OFF_CS2MD:  st_nxt.md[1] = pwdata[15:0] & `PPC_MSK_MD;
        `PPC_OFF_PAD:    st_nxt.pad = pwdata[15:0] & `PPC_MSK_PAD;
        `PPC_OFF_MADDR:  st_nxt.maddr = pwdata[23:0];
        `PPC_OFF_MWDATA: st_nxt.mwdata = pwdata[7:0];
        `PPC_OFF_SSTAT: begin
          // Writing zero clears a sticky flag, writing one keeps it
          st_nxt.in_ovf = st_r.in_ovf & pwdata[`PPC_F_INOVF];
          st_nxt.out_unf = st_r.out_unf & pwdata[`PPC_F_OUTUNF];
        end
        `PPC_OFF_MSTAT: begin
          st_nxt.err = st_r.err & pwdata[`PPC_F_ERR];
          st_nxt.tmo = st_r.tmo & pwdata[`PPC_F_TMO];
        end
        `PPC_OFF_MCMD: begin
          // A command while busy is dropped rather than queued
          if (!st_r.busy) begin
            st_nxt.is_rd = pwdata[`PPC_F_MCMD_RD];
            st_nxt.cur_md = cs2_hit ? st_r.md[1] : st_r.md[0];
            if (mode != `PPC_MODE_MST || !(cs1_hit || cs2_hit) ||
                (cs2_hit ? st_r.md[1][`PPC_F_ACKMODE] : st_r.md[0][`PPC_F_ACKMODE]) == `PPC_ACK_RSV) begin
              st_nxt.err = 1'b1;
            end else begin
              st_nxt.busy = 1'b1;
              st_nxt.ms = ppc_pkg::PPC_MS_AMW;
              st_nxt.cnt = 12'((`PPC_AMW_MIN + 32'(st_nxt.cur_md[`PPC_F_AMW])) * `PPC_TPT - 1);
            end
          end
        end
        default: begin
          if (is_buf) begin
            st_nxt.out_buf[bidx] = pwdata[7:0];
            st_nxt.ob_empty[{bidx[1], 1'b0} +: 2] = 2'b00;
          end
        end
      endcase
    end

    // External write into an input buffer
    if (x_wr_end) begin
      if (st_r.ib_full[x_widx]) begin
        st_nxt.in_ovf = 1'b1;
      end else begin
        st_nxt.ibuf[x_widx] = st_r.s3.din;
      end
      st_nxt.ib_full[x_widx] = 1'b1;
      st_nxt.wptr = (mode == `PPC_MODE_BUF) ? 2'(st_r.wptr + 2'h1) : 2'h0;
    end
    // External read from an output buffer; fresh software data wins
    if (x_rd_end) begin
      if (st_r.ob_empty[x_ridx]) begin
        st_nxt.out_unf = 1'b1;
      end
      if (!(apb_acc && pwrite && is_buf && bidx[1] == x_ridx[1])) begin
        st_nxt.ob_empty[{x_ridx[1], 1'b0} +: 2] = 2'b11;
      end
      st_nxt.rptr = (mode == `PPC_MODE_BUF) ? 2'(st_r.rptr + 2'h1) : 2'h0;
    end

    // Master sequencer
    case (st_r.ms)
      ppc_pkg::PPC_MS_IDLE: begin
        st_nxt.cnt = (st_nxt.ms == ppc_pkg::PPC_MS_IDLE) ? 12'h000 : st_nxt.cnt; // Keep a fresh wait count
      end
      ppc_pkg::PPC_MS_AMW: begin
        st_nxt.cnt = 12'(st_r.cnt - 12'h001);
        if (st_r.cnt == 12'h000) begin
          st_nxt.ms = ppc_pkg::PPC_MS_SETUP;
          st_nxt.cs1 = !cs2_hit;
          st_nxt.cs2 = cs2_hit;
          st_nxt.cnt = 12'(32'(st_r.cur_md[`PPC_F_DSETUP]) * `PPC_TPT + `PPC_QTR - 1);
        end
      end
      ppc_pkg::PPC_MS_SETUP: begin
        st_nxt.cnt = 12'(st_r.cnt - 12'h001);
        if (st_r.cnt == 12'h000) begin
          st_nxt.ms = ppc_pkg::PPC_MS_STROBE;
          st_nxt.rd = st_r.is_rd;
          st_nxt.wr = !st_r.is_rd;
          if (st_r.is_rd) begin
            st_nxt.cnt = 12'(32'(st_r.cur_md[`PPC_F_DSTRB]) * `PPC_TPT + 3 * `PPC_QTR - 1);
          end else begin
            st_nxt.cnt = 12'(32'(st_r.cur_md[`PPC_F_DSTRB]) * `PPC_TPT + 2 * `PPC_QTR - 1);
          end
          // Zero strobe wait selects the long limit
          if (st_r.cur_md[`PPC_F_DSTRB] == 4'h0) begin
            tmo_lim = 12'(`PPC_TMO_TCY * `PPC_TPT);
          end else begin
            tmo_lim = 12'(32'(st_r.cur_md[`PPC_F_DSTRB]) * `PPC_TPT);
          end
          st_nxt.tmo_cnt = 12'(tmo_lim - 12'h001);
        end
      end
      ppc_pkg::PPC_MS_STROBE: begin
        st_nxt.cnt = (st_r.cnt == 12'h000) ? 12'h000 : 12'(st_r.cnt - 12'h001);
        st_nxt.tmo_cnt = (st_r.tmo_cnt == 12'h000) ? 12'h000 : 12'(st_r.tmo_cnt - 12'h001);
        case (ack_sel)
          `PPC_ACK_WAIT: strb_end = st_r.s2.ack;
          `PPC_ACK_TMO: begin
            strb_end = st_r.s2.ack || (st_r.tmo_cnt == 12'h000);
            if (!st_r.s2.ack && st_r.tmo_cnt == 12'h000) begin
              st_nxt.tmo = 1'b1;
            end
          end
          default: strb_end = (st_r.cnt == 12'h000);
        endcase
        if (strb_end) begin
          st_nxt.rd = 1'b0;
          st_nxt.wr = 1'b0;
          if (st_r.is_rd) begin
            st_nxt.mrdata = st_r.s2.din;
            hold_t = 12'(32'(st_r.cur_md[`PPC_F_DHOLD]) * `PPC_TPT);
          end else begin
            hold_t = 12'(32'(st_r.cur_md[`PPC_F_DHOLD]) * `PPC_TPT + `PPC_QTR);
          end
          if (hold_t == 12'h000) begin
            fin = 1'b1;
          end else begin
            st_nxt.ms = ppc_pkg::PPC_MS_HOLD;
            st_nxt.cnt = 12'(hold_t - 12'h001);
          end
        end
      end
      ppc_pkg::PPC_MS_HOLD: begin
        st_nxt.cnt = 12'(st_r.cnt - 12'h001);
        fin = (st_r.cnt == 12'h000);
      end
      default: begin
        st_nxt.ms = ppc_pkg::PPC_MS_IDLE;
      end
    endcase
    if (fin) begin
      st_nxt.ms = ppc_pkg::PPC_MS_IDLE;
      st_nxt.cs1 = 1'b0;
      st_nxt.cs2 = 1'b0;
      st_nxt.busy = 1'b0;
    end

    // Bus drive: master write data, or output buffer during an external read
    if (st_nxt.ms != ppc_pkg::PPC_MS_IDLE && st_nxt.ms != ppc_pkg::PPC_MS_AMW && !st_r.is_rd) begin
      st_nxt.pd_out = st_r.mwdata;
      st_nxt.pd_oe_n = 1'b0;
    end else if (slave_on && st_r.s2.cs && st_r.s2.rd) begin
      st_nxt.pd_out = st_r.out_buf[x_ridx];
      st_nxt.pd_oe_n = 1'b0;
    end else begin
      st_nxt.pd_oe_n = 1'b1;
    end

    // Interrupt pulse
    if (st_r.ctrl[`PPC_F_IRQMODE] == `PPC_IRQ_BUF3) begin
      st_nxt.irq = (x_wr_end && x_widx == `PPC_LAST_BUF) || (x_rd_end && x_ridx == `PPC_LAST_BUF);
    end else if (st_r.ctrl[`PPC_F_IRQMODE] == `PPC_IRQ_END) begin
      st_nxt.irq = x_wr_end || x_rd_end || fin;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.base[0] <= `PPC_RST_CS1BS;
      st_r.base[1] <= `PPC_RST_CS2BS;
      st_r.ob_empty <= 4'hf;
      st_r.pd_oe_n <= 1'b1;
      st_r.ms <= ppc_pkg::PPC_MS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign pd_out = st_r.pd_out;
  assign pd_oe_n = st_r.pd_oe_n;
  assign ms_addr = st_r.maddr;
  assign ms_cs1 = st_r.cs1;
  assign ms_cs2 = st_r.cs2;
  assign ms_rd = st_r.rd;
  assign ms_wr = st_r.wr;
  assign irq_pulse = st_r.irq;
  assign input_buffer_type = st_r.pad[`PPC_F_PTTL];

  // Strobe length counter for checking only
  always_ff @(posedge clk) begin
    if (srst) begin
      sl_q <= '0;
    end else if (st_r.rd || st_r.wr) begin
      sl_q <= 12'(sl_q + 12'h001);
    end else begin
      sl_q <= '0;
    end
  end

  AST_RESET_BASE: assert property (@(posedge clk) !srst && $past(srst) |->
    (st_r.base[0] == `PPC_RST_CS1BS && st_r.base[1] == `PPC_RST_CS2BS && sstat[`PPC_F_OUTEMPTY]))
    else $error("Base registers or empty flag wrong after reset");
  AST_WRAP_CS1: assert property (@(posedge clk) disable iff (srst)
    (st_r.ms == ppc_pkg::PPC_MS_SETUP && st_r.base[1] == 16'h0000) |-> (st_r.cs1 && !st_r.cs2))
    else $error("Chip select 2 used while its base is zero");
  AST_ACK_IGNORED: assert property (@(posedge clk) disable iff (srst)
    (st_r.ms == ppc_pkg::PPC_MS_STROBE && ack_sel == `PPC_ACK_NONE && st_r.cnt != 12'h000) |=>
    (st_r.ms == ppc_pkg::PPC_MS_STROBE))
    else $error("Strobe ended early with ack ignored");
  AST_TIMEOUT_FLAG: assert property (@(posedge clk) disable iff (srst)
    (st_r.ms == ppc_pkg::PPC_MS_STROBE && ack_sel == `PPC_ACK_TMO && st_r.tmo_cnt == 12'h000 && !st_r.s2.ack)
    |=> (st_r.tmo && !st_r.rd && !st_r.wr))
    else $error("Time-out did not end strobe and set flag");
  AST_WR_WIDTH: assert property (@(posedge clk) disable iff (srst)
    ($fell(st_r.wr) && ack_sel == `PPC_ACK_NONE) |->
    (32'(sl_q) == 32'(st_r.cur_md[`PPC_F_DSTRB]) * `PPC_TPT + 2 * `PPC_QTR))
    else $error("Write strobe width wrong");
  AST_RD_WIDTH: assert property (@(posedge clk) disable iff (srst)
    ($fell(st_r.rd) && ack_sel == `PPC_ACK_NONE) |->
    (32'(sl_q) == 32'(st_r.cur_md[`PPC_F_DSTRB]) * `PPC_TPT + 3 * `PPC_QTR))
    else $error("Read strobe width wrong");
  AST_IB_PAIR_CLR: assert property (@(posedge clk) disable iff (srst)
    (apb_acc && !pwrite && is_buf && !x_wr_end) |=> (st_r.ib_full[{$past(bidx[1]), 1'b0} +: 2] == 2'b00))
    else $error("Input flag pair not cleared on read");
  AST_IN_OVF_SET: assert property (@(posedge clk) disable iff (srst)
    (x_wr_end && st_r.ib_full[x_widx]) |=> st_r.in_ovf [*2])
    else $error("Overflow flag not set or not sticky");
  AST_OUT_UNF_SET: assert property (@(posedge clk) disable iff (srst)
    (x_rd_end && st_r.ob_empty[x_ridx]) |=> st_r.out_unf)
    else $error("Underflow flag not set");
  AST_INFULL_ALL: assert property (@(posedge clk) disable iff (srst)
    (mode != `PPC_MODE_LEG && st_r.ib_full != 4'hf) |-> !sstat[`PPC_F_INFULL])
    else $error("Input-full flag set with an empty buffer");
endmodule

//--- dv/ppc_mem_model.sv
`timescale 1ns/1ps
// Far-side memory on the master port
module ppc_mem_model (
  // Clock
  input  wire logic        clk,
  // Bench controls
  input  wire logic        ack_en,
  input  wire logic [3:0]  ack_dly,
  // Master pins
  input  wire logic [23:0] ms_addr,
  input  wire logic        ms_rd,
  input  wire logic        ms_wr,
  output logic      [7:0]  mem_pd,
  output logic             ack
);
  logic [3:0] age = 4'h0;
  logic [7:0] last = 8'h00;
  initial ack = 1'b0;
  // Ack a set delay into the strobe; silent when disabled
  always @(posedge clk) begin
    age <= (ms_rd | ms_wr) ? age + 4'h1 : 4'h0;
    ack <= ack_en & (ms_rd | ms_wr) & (age >= ack_dly);
  end
  // Data only while read strobe; else a toggling pattern
  always @(posedge clk) begin
    last   <= ms_rd ? (8'ha5 ^ ms_addr[7:0]) : ~last;
    mem_pd <= ms_rd ? (8'ha5 ^ ms_addr[7:0]) : ~last;
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
`include "ppc_regs.svh"
module tb_top;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, pd_in, pd_out, tb_pd = 8'h00, mem_pd;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, pd_oe_n, ack, ack_en = 1'b0, irq_pulse, input_buffer_type;
  logic        ext_cs = 1'b0, ext_rd = 1'b0, ext_wr = 1'b0, ms_cs1, ms_cs2, ms_rd, ms_wr;
  logic [1:0]  ext_addr = 2'h0;
  logic [8:0]  xd;
  logic [23:0] ms_addr;
  int          mismatches = 0, checks = 0, scnt = 0, ccnt = 0, icnt = 0;
  // Slave strobes own the bus while selected
  assign pd_in = ext_cs ? tb_pd : mem_pd;
  always #50 clk = ~clk;
  // Strobe and select lengths in clocks
  always @(posedge clk) begin
    if (ms_rd | ms_wr) scnt++;
    if (ms_cs1) ccnt++;
    if (irq_pulse) icnt++;
  end
  ppc_top u_dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pd_in(pd_in), .pd_out(pd_out), .pd_oe_n(pd_oe_n), .ext_cs(ext_cs), .ext_rd(ext_rd),
    .ext_wr(ext_wr), .ext_addr(ext_addr), .acknowledge_input(ack), .ms_addr(ms_addr),
    .ms_cs1(ms_cs1), .ms_cs2(ms_cs2), .ms_rd(ms_rd), .ms_wr(ms_wr), .irq_pulse(irq_pulse),
    .input_buffer_type(input_buffer_type));
  ppc_mem_model u_mem (.clk(clk), .ack_en(ack_en), .ack_dly(4'h2), .ms_addr(ms_addr),
    .ms_rd(ms_rd), .ms_wr(ms_wr), .mem_pd(mem_pd), .ack(ack));
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; entered and left just after an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge clk);
    if (pready !== 1'b1) begin mismatches++; give_verdict; end
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Start a master cycle, poll busy, return strobe and select counts
  task automatic mgo(input logic r, input logic [15:0] md, output int ns, output int nc);
    int s, c, i;
    wr(`PPC_OFF_CS1MD, {16'h0, md});
    s = scnt; c = ccnt;
    wr(`PPC_OFF_MCMD, {31'h0, r});
    rd = 32'h8000;
    for (i = 0; i < 400 && rd[15] !== 1'b0; i++) apb(1'b0, `PPC_OFF_MSTAT, 32'h0);
    if (rd[15] !== 1'b0) begin mismatches++; give_verdict; end
    ns = scnt - s; nc = ccnt - c;
  endtask
  task automatic ext(input logic w, input logic [1:0] a, input logic [7:0] d);
    ext_cs <= 1'b1; ext_addr <= a; tb_pd <= d;
    repeat (4) @(posedge clk);
    ext_wr <= w; ext_rd <= !w;
    repeat (4) @(posedge clk);
    // Bus drive as it stood at that edge
    xd = {pd_oe_n, pd_out};
    ext_wr <= 1'b0; ext_rd <= 1'b0;
    repeat (4) @(posedge clk);
    ext_cs <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset;
    rdc(`PPC_OFF_CS1BS, 32'h0080);
    rdc(`PPC_OFF_CS2BS, 32'h8080);
    rdc(`PPC_OFF_SSTAT, 32'h008f);
    $display("test reset done");
  endtask
  // Setup, strobe and hold lengths for both directions
  task automatic t_master;
    int k, ds, sw, dh, ns, nc;
    wr(`PPC_OFF_CTRL, 32'h0300);
    wr(`PPC_OFF_MADDR, 32'h803c);
    for (k = 0; k < 3; k++) begin
      ds = k; sw = (k == 1) ? 15 : k; dh = 3 - k;
      mgo(1'b0, {8'h0, 2'(ds), 4'(sw), 2'(dh)}, ns, nc);
      chk(32'(ns), 32'(sw * 4 + 2));
      chk(32'(nc), 32'(ds * 4 + 1 + sw * 4 + 2 + dh * 4 + 1));
      mgo(1'b1, {8'h0, 2'(ds), 4'(sw), 2'(dh)}, ns, nc);
      chk(32'(ns), 32'(sw * 4 + 3));
      chk(32'(nc), 32'(ds * 4 + 1 + sw * 4 + 3 + dh * 4));
    end
    rdc(`PPC_OFF_MRDATA, 32'h99);
    // Above base 2: select 2 carries the cycle, then base 2 zero hands it to select 1
    wr(`PPC_OFF_MADDR, 32'h90_0000);
    mgo(1'b0, 16'h0, ns, nc);
    chk(32'(nc), 32'h0);
    chk(32'(ns), 32'h2);
    wr(`PPC_OFF_CS2BS, 32'h0);
    mgo(1'b0, 16'h0, ns, nc);
    chk(32'(nc), 32'h4);
    $display("test master timing done");
  endtask
  // Every ack mode with a prompt ack, then no ack at all
  task automatic t_ack;
    int k, ns, nc;
    ack_en <= 1'b1;
    for (k = 0; k < 4; k++) begin
      wr(`PPC_OFF_MSTAT, 32'h0);
      mgo(1'b0, {2'(k), 14'h0010}, ns, nc);
      chk({31'h0, ns < 18}, {31'h0, k != 0});
      rdc(`PPC_OFF_MSTAT, (k == 3) ? 32'h2000 : 32'h0);
    end
    ack_en <= 1'b0;
    wr(`PPC_OFF_MSTAT, 32'h0);
    mgo(1'b0, 16'h4008, ns, nc);
    rdc(`PPC_OFF_MSTAT, 32'h1000);
    mgo(1'b0, 16'h4000, ns, nc);
    chk({31'h0, ns > 1000}, 32'h1);
    wr(`PPC_OFF_MSTAT, 32'h0);
    rdc(`PPC_OFF_MSTAT, 32'h0);
    $display("test ack modes done");
  endtask
  // Addressable slave: flags, overflow, underflow, pair clearing
  task automatic t_slave;
    wr(`PPC_OFF_CTRL, 32'h0203);
    ext(1'b1, 2'h0, 8'h11);
    ext(1'b1, 2'h1, 8'h22);
    rdc(`PPC_OFF_SSTAT, 32'h038f);
    rdc(`PPC_OFF_BUF0, 32'h11);
    rdc(`PPC_OFF_SSTAT, 32'h008f);
    ext(1'b1, 2'h0, 8'h33);
    ext(1'b1, 2'h0, 8'h44);
    rdc(`PPC_OFF_SSTAT, 32'h418f);
    rdc(`PPC_OFF_BUF0, 32'h33);
    ext(1'b1, 2'h0, 8'h55);
    ext(1'b1, 2'h1, 8'h66);
    ext(1'b1, 2'h2, 8'h77);
    ext(1'b1, 2'h3, 8'h88);
    rdc(`PPC_OFF_SSTAT, 32'hcf8f);
    wr(`PPC_OFF_SSTAT, 32'h0);
    rdc(`PPC_OFF_SSTAT, 32'h8f8f);
    ext(1'b0, 2'h0, 8'h00);
    rdc(`PPC_OFF_SSTAT, 32'h8fcf);
    wr(`PPC_OFF_BUF0, 32'h12);
    rdc(`PPC_OFF_SSTAT, 32'h8f4c);
    ext(1'b0, 2'h0, 8'h00);
    chk(32'(xd), 32'h012);
    rdc(`PPC_OFF_SSTAT, 32'h8fcf);
    chk(32'(icnt), 32'h1);
    rdc(`PPC_OFF_BUF0, 32'h55);
    rdc(`PPC_OFF_BUF3, 32'h88);
    // Buffered slave ignores the address lines and fills in order
    wr(`PPC_OFF_CTRL, 32'h0100);
    ext(1'b1, 2'h3, 8'hab);
    ext(1'b1, 2'h3, 8'hcd);
    rdc(`PPC_OFF_BUF0 + 8'h04, 32'hcd);
    $display("test slave flags done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_master;
    t_ack;
    t_slave;
    give_verdict;
  end
endmodule
